// ### rtl/uft_pkg.sv
// Purpose: Shared constants and types of the USB host frame timer.
// Assumes: Controller clock of 100 MHz and a full-speed rate of 12 Mbit/s.
// Notes:   Command codes are the register port's read and write codes.
package uft_pkg;

  // Clock and bit-rate figures in kHz.
  localparam int UFT_CLK_KHZ    = 100000;
  localparam int UFT_FS_BIT_KHZ = 12000;

  // Field widths.
  localparam int UFT_FR_W  = 14;
  localparam int UFT_FN_W  = 16;
  localparam int UFT_LST_W = 11;

  // Field positions inside the 32-bit register words.
  localparam int UFT_TOGGLE_POS = 31;
  localparam int UFT_FR_LSB     = 0;
  localparam int UFT_FN_LSB     = 0;
  localparam int UFT_LST_LSB    = 0;
  localparam int UFT_FI_LSB     = 0;

  // Command codes.
  localparam logic [7:0] UFT_CODE_FI_RD  = 8'h0D;
  localparam logic [7:0] UFT_CODE_FI_WR  = 8'h8D;
  localparam logic [7:0] UFT_CODE_FR_RD  = 8'h0E;
  localparam logic [7:0] UFT_CODE_FN_RD  = 8'h0F;
  localparam logic [7:0] UFT_CODE_LST_RD = 8'h11;
  localparam logic [7:0] UFT_CODE_LST_WR = 8'h91;

  // Reset values.
  localparam logic [13:0] UFT_FI_RST  = 14'h2EDF;
  localparam logic [10:0] UFT_LST_RST = 11'h628;
  localparam logic [13:0] UFT_FR_RST  = 14'h0000;
  localparam logic [15:0] UFT_FN_RST  = 16'h0000;
  localparam logic        UFT_TGL_RST = 1'b0;

  typedef enum logic [0:0] {
    UFT_IDLE = 1'b0,
    UFT_RUN  = 1'b1
  } uft_state_e;

endpackage

// ### rtl/uft_bit_tick.sv
// Purpose: Full-speed bit-time tick from the controller clock.
// Assumes: BIT_KHZ is below CLK_KHZ.
// Notes:   A phase accumulator spreads the fractional ratio evenly.
`timescale 1ns/1ps
`default_nettype none
module uft_bit_tick
  import uft_pkg::*;
#(
  parameter int CLK_KHZ = UFT_CLK_KHZ,
  parameter int BIT_KHZ = UFT_FS_BIT_KHZ
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Tick out
  output logic      tick
);

  localparam int ACC_W = $clog2(CLK_KHZ + BIT_KHZ + 1);
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(BIT_KHZ);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_KHZ);

  logic [ACC_W-1:0] acc_ff;
  logic [ACC_W-1:0] nxt_acc;
  logic             tick_ff;
  logic             nxt_tick;

  always_comb begin
    logic [ACC_W-1:0] sum;
    sum      = acc_ff + ACC_STEP;
    nxt_tick = 1'b0;
    nxt_acc  = sum;
    if (sum >= ACC_WRAP) begin
      nxt_acc  = sum - ACC_WRAP;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      acc_ff  <= nxt_acc;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule
`default_nettype wire

// ### rtl/uft_cmd_port.sv
// Purpose: Command-code register port of the frame timer.
// Assumes: One command per cmd_valid cycle; answers one cycle later.
// Notes:   Holds the frame period fields and the slow commit threshold.
`timescale 1ns/1ps
`default_nettype none
module uft_cmd_port
  import uft_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 ctrl_reset_cmd,
  input  wire logic                 running,
  // Command side
  input  wire logic                 cmd_valid,
  input  wire logic [7:0]           cmd_code,
  input  wire logic [31:0]          wr_data,
  output logic      [31:0]          rd_data,
  output logic                      cmd_ack,
  output logic                      cmd_err,
  // Counter state to report
  input  wire logic [UFT_FR_W-1:0]  frame_left_count,
  input  wire logic                 remaining_toggle,
  input  wire logic [UFT_FN_W-1:0]  frame_count,
  // Held fields
  output logic [UFT_FR_W-1:0]       frame_period,
  output logic                      period_toggle,
  output logic [UFT_LST_W-1:0]      slow_commit_threshold
);

  function automatic logic code_known(input logic [7:0] c);
    code_known = (c == UFT_CODE_FI_RD) || (c == UFT_CODE_FI_WR) ||
                 (c == UFT_CODE_FR_RD) || (c == UFT_CODE_FN_RD) ||
                 (c == UFT_CODE_LST_RD) || (c == UFT_CODE_LST_WR);
  endfunction

  logic [31:0]          rd_ff, nxt_rd;
  logic                 ack_ff, nxt_ack;
  logic                 err_ff, nxt_err;
  logic [UFT_FR_W-1:0]  fi_ff, nxt_fi;
  logic                 fit_ff, nxt_fit;
  logic [UFT_LST_W-1:0] lst_ff, nxt_lst;

  always_comb begin
    nxt_rd  = rd_ff;
    nxt_ack = 1'b0;
    nxt_err = 1'b0;
    nxt_fi  = fi_ff;
    nxt_fit = fit_ff;
    nxt_lst = lst_ff;
    if (cmd_valid) begin
      nxt_ack = code_known(cmd_code);
      nxt_err = !code_known(cmd_code);
      nxt_rd  = 32'h0000_0000;
      case (cmd_code)
        UFT_CODE_FI_RD: begin
          nxt_rd[UFT_TOGGLE_POS] = fit_ff;
          nxt_rd[UFT_FI_LSB +: UFT_FR_W] = fi_ff;
        end
        UFT_CODE_FI_WR: begin
          nxt_fit = wr_data[UFT_TOGGLE_POS];
          nxt_fi  = wr_data[UFT_FI_LSB +: UFT_FR_W];
        end
        UFT_CODE_FR_RD: begin
          nxt_rd[UFT_TOGGLE_POS] = remaining_toggle;
          nxt_rd[UFT_FR_LSB +: UFT_FR_W] = frame_left_count;
        end
        UFT_CODE_FN_RD: begin
          nxt_rd[UFT_FN_LSB +: UFT_FN_W] = frame_count;
        end
        UFT_CODE_LST_RD: begin
          nxt_rd[UFT_LST_LSB +: UFT_LST_W] = lst_ff;
        end
        UFT_CODE_LST_WR: begin
          // Reserved bits are dropped; the value is frozen while running.
          if (!running) begin
            nxt_lst = wr_data[UFT_LST_LSB +: UFT_LST_W];
          end
        end
        default: begin
          nxt_rd = 32'h0000_0000;
        end
      endcase
    end
    if (ctrl_reset_cmd) begin
      nxt_fi  = UFT_FI_RST;
      nxt_fit = UFT_TGL_RST;
      nxt_lst = UFT_LST_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_ff  <= 32'h0000_0000;
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      fi_ff  <= UFT_FI_RST;
      fit_ff <= UFT_TGL_RST;
      lst_ff <= UFT_LST_RST;
    end else begin
      rd_ff  <= nxt_rd;
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
      fi_ff  <= nxt_fi;
      fit_ff <= nxt_fit;
      lst_ff <= nxt_lst;
    end
  end

  assign rd_data               = rd_ff;
  assign cmd_ack               = ack_ff;
  assign cmd_err               = err_ff;
  assign frame_period          = fi_ff;
  assign period_toggle         = fit_ff;
  assign slow_commit_threshold = lst_ff;

endmodule
`default_nettype wire

// ### rtl/uft_frame_timer.sv
// Purpose: Frame timing unit of a USB host controller.
// Assumes: Control inputs come from logic on the same clock.
// Notes:   Counters move only on the bit-time tick, on operational entry or on a controller reset command.
`timescale 1ns/1ps
`default_nettype none
module uft_frame_timer
  import uft_pkg::*;
#(
  parameter int CLK_KHZ = UFT_CLK_KHZ,
  parameter int BIT_KHZ = UFT_FS_BIT_KHZ
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // Controller state
  input  wire logic                 operational_state,
  input  wire logic                 controller_reset_command,
  // Command port
  input  wire logic                 cmd_valid,
  input  wire logic [7:0]           cmd_code,
  input  wire logic [31:0]          wr_data,
  output logic      [31:0]          rd_data,
  output logic                      cmd_ack,
  output logic                      cmd_err,
  // Slow transaction gate
  input  wire logic                 slow_req,
  output logic                      slow_grant,
  output logic                      slow_deny,
  // Timing outputs
  output logic                      bit_tick,
  output logic                      frame_start_flag,
  output logic [UFT_FR_W-1:0]       frame_left_count,
  output logic                      remaining_toggle,
  output logic [UFT_FN_W-1:0]       frame_count
);

  uft_state_e           state_ff, nxt_state;
  logic [UFT_FR_W-1:0]  fr_ff, nxt_fr;
  logic                 frt_ff, nxt_frt;
  logic [UFT_FN_W-1:0]  fn_ff, nxt_fn;
  logic                 sof_ff, nxt_sof;
  logic                 tick;
  logic                 entry;
  logic                 running;
  logic [UFT_FR_W-1:0]  frame_period;
  logic                 period_toggle;
  logic [UFT_LST_W-1:0] slow_commit_threshold;

  uft_bit_tick #(
    .CLK_KHZ (CLK_KHZ),
    .BIT_KHZ (BIT_KHZ)
  ) u_tick (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick)
  );

  uft_cmd_port u_cmd (
    .clk                   (clk),
    .rstn                  (rstn),
    .ctrl_reset_cmd        (controller_reset_command),
    .running               (running),
    .cmd_valid             (cmd_valid),
    .cmd_code              (cmd_code),
    .wr_data               (wr_data),
    .rd_data               (rd_data),
    .cmd_ack               (cmd_ack),
    .cmd_err               (cmd_err),
    .frame_left_count      (fr_ff),
    .remaining_toggle      (frt_ff),
    .frame_count           (fn_ff),
    .frame_period          (frame_period),
    .period_toggle         (period_toggle),
    .slow_commit_threshold (slow_commit_threshold)
  );

  assign running = (state_ff == UFT_RUN);
  assign entry   = (state_ff == UFT_IDLE) && operational_state &&
                   !controller_reset_command;

  // Counter group.
  always_comb begin
    nxt_state = state_ff;
    nxt_fr    = fr_ff;
    nxt_frt   = frt_ff;
    nxt_fn    = fn_ff;
    nxt_sof   = 1'b0;
    case (state_ff)
      UFT_IDLE: begin
        if (entry) begin
          nxt_state = UFT_RUN;
          nxt_fr    = frame_period;
          nxt_fn    = fn_ff + 16'h0001;
          nxt_sof   = 1'b1;
        end
      end
      UFT_RUN: begin
        if (!operational_state) begin
          nxt_state = UFT_IDLE;
        end else if (tick) begin
          if (fr_ff == UFT_FR_RST) begin
            // The period is sampled here, so a new value takes effect
            // only from the next frame start.
            nxt_fr  = frame_period;
            nxt_frt = period_toggle;
            nxt_fn  = fn_ff + 16'h0001;
            nxt_sof = 1'b1;
          end else begin
            nxt_fr = fr_ff - 14'h0001;
          end
        end
      end
      default: begin
        nxt_state = UFT_IDLE;
      end
    endcase
    if (controller_reset_command) begin
      nxt_state = UFT_IDLE;
      nxt_fr    = UFT_FR_RST;
      nxt_frt   = UFT_TGL_RST;
      nxt_fn    = UFT_FN_RST;
      nxt_sof   = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff <= UFT_IDLE;
      fr_ff    <= UFT_FR_RST;
      frt_ff   <= UFT_TGL_RST;
      fn_ff    <= UFT_FN_RST;
      sof_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      fr_ff    <= nxt_fr;
      frt_ff   <= nxt_frt;
      fn_ff    <= nxt_fn;
      sof_ff   <= nxt_sof;
    end
  end

  // The gate answers in the request cycle against the current count.
  assign slow_grant = slow_req && running &&
                      (fr_ff >= {3'h0, slow_commit_threshold});
  assign slow_deny  = slow_req && !slow_grant;

  assign bit_tick         = tick;
  assign frame_start_flag = sof_ff;
  assign frame_left_count = fr_ff;
  assign remaining_toggle = frt_ff;
  assign frame_count      = fn_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // A sequence, so that it may stand in an antecedent with a boolean.
  sequence p_quiet_step;
    !controller_reset_command && running && operational_state;
  endsequence

  AST_FR_DEC: assert property (
    (p_quiet_step and tick && fr_ff != 14'h0000)
    |=> fr_ff == 14'($past(fr_ff) - 14'h0001))
    else $error("remaining count did not step down by one");

  AST_FR_RELOAD: assert property (
    (p_quiet_step and tick && fr_ff == 14'h0000)
    |=> fr_ff == $past(frame_period) && sof_ff)
    else $error("remaining count not reloaded at zero");

  AST_FRT_COPY: assert property (
    (p_quiet_step and tick && fr_ff == 14'h0000)
    |=> frt_ff == $past(period_toggle))
    else $error("toggle not copied at frame reload");

  AST_ENTRY: assert property (
    entry |=> running && fr_ff == $past(frame_period) &&
              fn_ff == 16'($past(fn_ff) + 16'h0001) && sof_ff)
    else $error("operational entry did not load and count");

  AST_FN_WRAP: assert property (
    (fn_ff == 16'hFFFF && nxt_sof) |=> fn_ff == 16'h0000)
    else $error("frame count did not wrap to zero");

  AST_FN_SOF: assert property (
    ($past(rstn) && !$past(controller_reset_command) &&
     fn_ff != $past(fn_ff)) |-> sof_ff)
    else $error("frame count moved without a frame start");

  AST_SOF_ONCE: assert property (
    sof_ff |=> !sof_ff)
    else $error("frame start flag held longer than one cycle");

  AST_NO_TICK_HOLD: assert property (
    (!tick && !entry && !controller_reset_command && $past(rstn))
    |=> fr_ff == $past(fr_ff) && fn_ff == $past(fn_ff))
    else $error("counter moved without a bit tick");

  AST_TICK_PULSE: assert property (
    tick |=> !tick)
    else $error("bit tick wider than one cycle");

  AST_SLOW_GATE: assert property (
    slow_grant |-> running && fr_ff >= {3'h0, slow_commit_threshold})
    else $error("slow transaction granted below threshold");

  AST_SLOW_DENY: assert property (
    (slow_req && running && fr_ff < {3'h0, slow_commit_threshold})
    |-> slow_deny && !slow_grant)
    else $error("slow transaction not refused below threshold");

  AST_LST_FROZEN: assert property (
    (running && !controller_reset_command)
    |=> slow_commit_threshold == $past(slow_commit_threshold))
    else $error("threshold changed while running");

  AST_RD_FR: assert property (
    (cmd_valid && cmd_code == UFT_CODE_FR_RD)
    |=> cmd_ack && rd_data == {$past(frt_ff), 17'h00000, $past(fr_ff)})
    else $error("remaining register read returned wrong word");

  AST_RD_FN: assert property (
    (cmd_valid && cmd_code == UFT_CODE_FN_RD)
    |=> cmd_ack && rd_data == {16'h0000, $past(fn_ff)})
    else $error("frame number read returned wrong word");

  AST_RST_PERIOD: assert property (
    controller_reset_command |=> frame_period == UFT_FI_RST)
    else $error("controller reset did not restore period");

  AST_CRC_CLEAR: assert property (
    controller_reset_command
    |=> !running && fr_ff == 14'h0000 && fn_ff == 16'h0000 && !sof_ff)
    else $error("controller reset did not clear the counters");

  AST_RD_LST: assert property (
    (cmd_valid && cmd_code == UFT_CODE_LST_RD)
    |=> cmd_ack && rd_data == {21'h000000, $past(slow_commit_threshold)})
    else $error("threshold read returned wrong word");

  AST_LST_WR: assert property (
    (cmd_valid && cmd_code == UFT_CODE_LST_WR && !running &&
     !controller_reset_command)
    |=> slow_commit_threshold == $past(wr_data[UFT_LST_W-1:0]))
    else $error("threshold write while idle did not land");

  AST_NO_FR_WR: assert property (
    (cmd_valid && cmd_code == 8'h8E)
    |=> cmd_err && !cmd_ack && rd_data == 32'h0000_0000)
    else $error("write code for remaining register was accepted");

  AST_NO_FN_WR: assert property (
    (cmd_valid && cmd_code == 8'h8F)
    |=> cmd_err && !cmd_ack && rd_data == 32'h0000_0000)
    else $error("write code for frame number register was accepted");

  AST_RD_RSVD: assert property (
    cmd_valid |=> rd_data[30:16] == 15'h0000)
    else $error("reserved read bits were not zero");

  AST_IDLE_FROZEN: assert property (
    (!running && !entry && !controller_reset_command)
    |=> fr_ff == $past(fr_ff) && fn_ff == $past(fn_ff) && !sof_ff)
    else $error("counters moved while not operational");

  AST_FRT_HOLD: assert property (
    (!controller_reset_command && !(tick && fr_ff == 14'h0000))
    |=> frt_ff == $past(frt_ff))
    else $error("remaining toggle changed outside a reload");

  AST_WR_PERIOD: assert property (
    (cmd_valid && cmd_code == UFT_CODE_FI_WR && !controller_reset_command)
    |=> frame_period == $past(wr_data[UFT_FR_W-1:0]) &&
        period_toggle == $past(wr_data[UFT_TOGGLE_POS]))
    else $error("frame period write did not land");

  COV_RELOAD: cover property (
    p_quiet_step and tick && fr_ff == 14'h0000);
  COV_WRAP: cover property (fn_ff == 16'hFFFF ##1 fn_ff == 16'h0000);
  COV_GRANT: cover property (slow_grant);
  COV_ENTRY: cover property (entry);
  COV_DENY: cover property (slow_req && running && slow_deny);

endmodule
`default_nettype wire

// ### bench/tb_usb_host_frame_timer.sv
// Purpose: Self-checking bench of the USB host frame timer.
// Assumes: A fast bit tick keeps frames and the frame count wrap short.
// Notes:   A cycle model predicts counters, start flag and slow gate.
`timescale 1ns/1ps
`default_nettype none
module tb_usb_host_frame_timer
  import uft_pkg::*;
;
  localparam int CK  = 100000;
  // Half the clock rate: the fastest tick that stays a one-cycle pulse.
  localparam int BK  = 50000;
  localparam int GAP = CK / BK;

  logic        clk, rstn, op, crc, cmd_valid, slow_req;
  logic [7:0]  cmd_code;
  logic [31:0] wr_data, rd_data;
  logic        cmd_ack, cmd_err, slow_grant, slow_deny, bit_tick;
  logic        start_flag, rem_tgl, chk_on, tick_s, g;
  logic [13:0] left_cnt, m_left, m_per;
  logic [15:0] frm_cnt, m_cnt;
  logic [10:0] m_thr;
  logic        m_run, m_ptgl, m_rtgl, m_flag, m_wrap;
  logic [3:0]  cyc;
  logic [7:0]  codes [8];
  int          errors, n_tests, gap;

  uft_frame_timer #(.CLK_KHZ(CK), .BIT_KHZ(BK)) i_uft_frame_timer (
    .clk(clk), .rstn(rstn), .operational_state(op),
    .controller_reset_command(crc), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .wr_data(wr_data), .rd_data(rd_data),
    .cmd_ack(cmd_ack), .cmd_err(cmd_err), .slow_req(slow_req),
    .slow_grant(slow_grant), .slow_deny(slow_deny), .bit_tick(bit_tick),
    .frame_start_flag(start_flag), .frame_left_count(left_cnt),
    .remaining_toggle(rem_tgl), .frame_count(frm_cnt)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [31:0] rd_exp(input logic [7:0] c);
    case (c)
      8'h0D:   return {m_ptgl, 17'h0, m_per};
      8'h0E:   return {m_rtgl, 17'h0, m_left};
      8'h0F:   return {16'h0, m_cnt};
      8'h11:   return {21'h0, m_thr};
      default: return 32'h0;
    endcase
  endfunction

  // One command per call; the answer is judged at the falling edge after it is taken.
  task automatic cmd(input logic [7:0] c, input logic [31:0] d);
    logic [31:0] e;
    logic        k;
    @(negedge clk);
    e = rd_exp(c);
    k = c inside {8'h0D, 8'h8D, 8'h0E, 8'h0F, 8'h11, 8'h91};
    cmd_valid = 1'b1;
    cmd_code  = c;
    wr_data   = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    chk("rd_data", e, rd_data);
    chk("cmd_ack", {31'h0, k}, {31'h0, cmd_ack});
    chk("cmd_err", {31'h0, !k}, {31'h0, cmd_err});
  endtask

  // Reference state moves on the rising edge from inputs held since the
  // falling edge, so it never races the design's own updates.
  always @(posedge clk) begin
    m_flag = 1'b0;
    if (!rstn || crc) begin
      m_run  = 1'b0;
      m_left = 14'h0;
      m_rtgl = 1'b0;
      m_cnt  = 16'h0;
      m_per  = 14'h2EDF;
      m_ptgl = 1'b0;
      m_thr  = 11'h628;
    end else begin
      if (!m_run && op) begin
        m_run  = 1'b1;
        m_left = m_per;
        m_cnt  = m_cnt + 16'h1;
        m_flag = 1'b1;
      end else if (m_run && tick_s) begin
        if (m_left != 14'h0) begin
          m_left = m_left - 14'h1;
        end else begin
          m_left = m_per;
          m_rtgl = m_ptgl;
          m_wrap = m_wrap | (m_cnt == 16'hFFFF);
          m_cnt  = m_cnt + 16'h1;
          m_flag = 1'b1;
        end
      end
      if (cmd_valid && cmd_code == 8'h8D) begin
        m_per  = wr_data[13:0];
        m_ptgl = wr_data[31];
      end
      if (cmd_valid && cmd_code == 8'h91 && !m_run) begin
        m_thr = wr_data[10:0];
      end
    end
  end

  always @(negedge clk) begin
    tick_s = bit_tick;
    slow_req <= cyc[0] ^ cyc[2];
    cyc <= cyc + 4'h1;
    if (chk_on) begin
      g = slow_req && m_run && (m_left >= {3'h0, m_thr});
      chk("frame_left_count", {18'h0, m_left}, {18'h0, left_cnt});
      chk("remaining_toggle", {31'h0, m_rtgl}, {31'h0, rem_tgl});
      chk("frame_count", {16'h0, m_cnt}, {16'h0, frm_cnt});
      chk("frame_start_flag", {31'h0, m_flag}, {31'h0, start_flag});
      chk("slow_grant", {31'h0, g}, {31'h0, slow_grant});
      chk("slow_deny", {31'h0, slow_req && !g}, {31'h0, slow_deny});
      if (gap >= 0) gap = gap + 1;
      if (bit_tick) begin
        if (gap > 0) chk("tick_gap", 32'h1,
                         {31'h0, gap == GAP || gap == GAP + 1});
        gap = 0;
      end
    end
  end

  initial begin
    rstn      = 1'b0;
    op        = 1'b0;
    crc       = 1'b0;
    cmd_valid = 1'b0;
    cmd_code  = 8'h00;
    wr_data   = 32'h0;
    slow_req  = 1'b0;
    cyc       = 4'h0;
    tick_s    = 1'b0;
    chk_on    = 1'b0;
    m_wrap    = 1'b0;
    errors    = 0;
    n_tests   = 0;
    gap       = -1;
    codes = '{8'h0D, 8'h0E, 8'h0F, 8'h11, 8'h8E, 8'h8F, 8'h00, 8'hFF};
    repeat (5) @(negedge clk);
    rstn   = 1'b1;
    chk_on = 1'b1;
    foreach (codes[i]) cmd(codes[i], 32'hFFFF_FFFF);
    // Ticks while idle must leave every counter alone.
    repeat (20) @(negedge clk);
    cmd(8'h91, 32'hFFFF_F80A);
    cmd(8'h11, 32'h0);
    cmd(8'h8D, 32'h0000_0014);
    @(negedge clk);
    op = 1'b1;
    repeat (70) @(negedge clk);
    cmd(8'h91, 32'h0000_0003);
    cmd(8'h11, 32'h0);
    cmd(8'h8D, 32'h8000_000C);
    repeat (40) @(negedge clk);
    foreach (codes[i]) cmd(codes[i], 32'h0);
    cmd(8'h8D, 32'h0);
    for (int i = 0; i < 140000 && !m_wrap; i++) @(negedge clk);
    chk("frame_count_wrap", 32'h1, {31'h0, m_wrap});
    crc = 1'b1;
    @(negedge clk);
    crc = 1'b0;
    repeat (5) @(negedge clk);
    foreach (codes[i]) cmd(codes[i], 32'h0);
    give_verdict();
  end

  // The wrap takes one frame per two cycles, about 131000 cycles in all.
  initial begin
    repeat (150000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
